/* File: fcct_pkg.sv */
// Purpose: shared constants for the four-channel counter/timer
// Assumes: one 40 MHz system clock, host on a parallel I/O bus
// Notes:   control word bit positions, vector layout, prescaler counts and opcodes
package fcct_pkg;
    // ==========================================================
    // sizes
    localparam int unsigned NUM_CH   = 4;
    localparam int unsigned DATA_W   = 8;
    localparam int unsigned SEL_W    = 2;
    localparam int unsigned PRE_W    = 8;
    // ==========================================================
    // control word fields
    localparam int unsigned CW_IE_BIT    = 7;
    localparam int unsigned CW_MODE_BIT  = 6;
    localparam int unsigned CW_PRE_BIT   = 5;
    localparam int unsigned CW_EDGE_BIT  = 4;
    localparam int unsigned CW_TRIG_BIT  = 3;
    localparam int unsigned CW_TC_BIT    = 2;
    localparam int unsigned CW_RST_BIT   = 1;
    localparam int unsigned CW_CTRL_BIT  = 0;
    localparam logic [7:0]  CW_RESET_VAL = 8'h00;
    // ==========================================================
    // vector layout
    localparam int unsigned VEC_BASE_LSB = 3;
    localparam int unsigned VEC_BASE_W   = 5;
    localparam logic [7:0]  VEC_RESET    = 8'h00;
    // ==========================================================
    // prescaler terminal counts (divide by 16 or 256)
    localparam logic [7:0]  PRE_LAST_16  = 8'h0f;
    localparam logic [7:0]  PRE_LAST_256 = 8'hff;
    localparam logic [7:0]  CNT_ZERO     = 8'h00;
    localparam logic [7:0]  CNT_ONE      = 8'h01;
    // ==========================================================
    // return-from-interrupt opcode bytes
    localparam logic [7:0]  RET_OP_PREFIX = 8'hed;
    localparam logic [7:0]  RET_OP_SECOND = 8'h4d;
endpackage : fcct_pkg

/* File: fcct_sync.sv */
// Purpose: two flip-flop synchroniser for one pin level
// Assumes: input asynchronous to clk_i
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module fcct_sync (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic d_i,
    output logic      q_o
);
    typedef struct packed {
        logic s1;
        logic s2;
    } fcct_sync_s;
    fcct_sync_s st_q;
    fcct_sync_s st_d;

    // ==========================================================
    // shift chain
    always_comb begin
        st_d    = st_q;
        st_d.s1 = d_i;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q_o = st_q.s2;
endmodule : fcct_sync
`default_nettype wire

/* File: fcct_channel.sv */
// Purpose: one counter/timer channel: control, constant, prescaler, down-counter
// Assumes: trigger input already synchronised; write strobe is one cycle
// Notes:   zero time constant byte means 256
`timescale 1ns/1ps
`default_nettype none
module fcct_channel #(
    parameter int unsigned DW = fcct_pkg::DATA_W
) (
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          wr_i,
    input  wire logic [DW-1:0] wdata_i,
    input  wire logic          trig_i,
    output logic [DW-1:0]      count_o,
    output logic [DW-1:0]      ctrl_o,
    output logic               zero_o
);
    typedef struct packed {
        logic [DW-1:0] ctrl;
        logic [DW-1:0] tc;
        logic [DW-1:0] cnt;
        logic [7:0]    pre;
        logic          tc_next;
        logic          running;
        logic          waiting;
        logic          trig_old;
        logic          zero;
    } fcct_ch_s;
    fcct_ch_s st_q;
    fcct_ch_s st_d;

    logic is_ctrl;
    logic edge_hit;
    logic pre_tick;
    logic step;

    // ==========================================================
    // edge and tick detection
    always_comb begin
        is_ctrl  = wdata_i[fcct_pkg::CW_CTRL_BIT];
        edge_hit = st_q.ctrl[fcct_pkg::CW_EDGE_BIT] ? (trig_i & ~st_q.trig_old)
                                                    : (~trig_i & st_q.trig_old);
        pre_tick = (st_q.pre == (st_q.ctrl[fcct_pkg::CW_PRE_BIT] ?
                   fcct_pkg::PRE_LAST_256 : fcct_pkg::PRE_LAST_16));
        step     = st_q.running & (st_q.ctrl[fcct_pkg::CW_MODE_BIT] ? edge_hit
                                                                    : pre_tick);
    end

    // ==========================================================
    // next state
    always_comb begin
        st_d          = st_q;
        st_d.trig_old = trig_i;
        st_d.zero     = 1'b0;
        // prescaler runs only while timing
        if (st_q.running && !st_q.ctrl[fcct_pkg::CW_MODE_BIT]) begin
            st_d.pre = pre_tick ? 8'h00 : st_q.pre + 8'h01;
        end else begin
            st_d.pre = 8'h00;
        end
        // waiting for trigger edge before timing starts
        if (st_q.waiting && edge_hit) begin
            st_d.waiting = 1'b0;
            st_d.running = 1'b1;
        end
        // count; wrap at one so zero byte (256) takes a full pass
        if (step) begin
            if (st_q.cnt == fcct_pkg::CNT_ONE) begin
                st_d.cnt  = st_q.tc;
                st_d.zero = 1'b1;
            end else begin
                st_d.cnt = st_q.cnt - 8'h01;
            end
        end
        // host writes
        if (wr_i) begin
            if (st_q.tc_next) begin
                st_d.tc      = wdata_i;
                st_d.tc_next = 1'b0;
                // constant taken: later bytes with bit 0 clear are vector words
                st_d.ctrl[fcct_pkg::CW_TC_BIT] = 1'b0;
                // a running channel keeps its count until zero
                if (!st_q.running) begin
                    st_d.cnt = wdata_i;
                    if (st_q.ctrl[fcct_pkg::CW_MODE_BIT] ||
                        !st_q.ctrl[fcct_pkg::CW_TRIG_BIT]) begin
                        st_d.running = 1'b1;
                    end else begin
                        st_d.waiting = 1'b1;
                    end
                end
            end else if (is_ctrl) begin
                st_d.ctrl    = wdata_i;
                st_d.tc_next = wdata_i[fcct_pkg::CW_TC_BIT];
                if (wdata_i[fcct_pkg::CW_RST_BIT]) begin
                    st_d.running = 1'b0;
                    st_d.waiting = 1'b0;
                    st_d.zero    = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign count_o = st_q.cnt;
    assign ctrl_o  = st_q.ctrl;
    assign zero_o  = st_q.zero;
endmodule : fcct_channel
`default_nettype wire

/* File: fcct_top.sv */
// Purpose: four-channel 8-bit counter/timer with daisy-chain vectored interrupts
// Assumes: host bus strobes are synchronous to clk_i, active low, one access
//          per strobe assertion; triggers are asynchronous pins
// Notes:   data bus split into in/out/enable, enable low while driving
// How it works
// - each channel has 8-bit constant, control, readable down-counter, prescaler
// - control and constant writes and reads go to the channel named by select code
// - select code is hi input as msb, lo input as lsb
// - written bit 0 one is control word, zero is vector word
// - control bits 7..4 are irq enable, mode, prescale, trigger edge
// - timer mode bit 3 waits for trigger edge, else starts on load
// - bit 2 means constant follows; bit 1 soft-resets the channel
// - prescaler runs in timer mode only, dividing clock by 16 or 256
// - counter mode steps per trigger edge, timer mode per prescaler tick
// - on reaching zero the counter reloads from the constant
// - constants 1 through 256 are accepted in both modes
// - new constant while running loads only after current count ends
// - a read returns the selected channel's down-counter
// - channels 0-2 pulse zero-count output high at zero; channel 3 none
// - enabled channel requests an interrupt at every zero
// - channel 0 has highest priority, channel 3 lowest
// - lower priority waits behind unfinished higher service; higher may nest
// - chain out high only if chain in high and nothing in service
// - acknowledge with chain in high drives base, channel code, zero
// - return opcode seen on bus ends in-service of serviced channel
// - reset stops counting and clears interrupt enables
`timescale 1ns/1ps
`default_nettype none
module fcct_top #(
    parameter int unsigned NCH = fcct_pkg::NUM_CH,
    parameter int unsigned DW  = fcct_pkg::DATA_W
) (
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          chip_en_n_i,
    input  wire logic          ioreq_n_i,
    input  wire logic          rd_n_i,
    input  wire logic          m1_n_i,
    input  wire logic          channel_select_lo_i,
    input  wire logic          channel_select_hi_i,
    input  wire logic [DW-1:0] data_i,
    output logic [DW-1:0]      data_o,
    output logic               data_oe_n_o,
    input  wire logic [NCH-1:0] count_trigger_in_i,
    output logic [2:0]         zero_count_pulse_out_o,
    output logic               int_n_o,
    output logic               int_oe_n_o,
    input  wire logic          priority_chain_in_i,
    output logic               priority_chain_out_o
);
    typedef struct packed {
        logic [DW-1:0]  rdata;
        logic           drive;
        logic           acc_old;
        logic [4:0]     vec_base;
        logic [NCH-1:0] pend;
        logic [NCH-1:0] insvc;
        logic           saw_prefix;
        logic           fetch_old;
        logic [2:0]     zc;
        logic           irq;
        logic           chain_out;
    } fcct_top_s;
    fcct_top_s st_q;
    fcct_top_s st_d;

    logic [NCH-1:0]         trig_s;
    logic [NCH-1:0]         wr_ch;
    logic [NCH-1:0]         zero;
    logic [NCH-1:0][DW-1:0] cnt;
    logic [NCH-1:0][DW-1:0] ctrl;
    logic [1:0]             sel;
    logic                   io_acc;
    logic                   wr_stb;
    logic                   ack;
    logic                   fetch;
    logic                   fetch_end;
    logic [NCH-1:0]         svc_mask;
    logic [NCH-1:0]         pend_next;
    logic [1:0]             win_code;
    logic                   win_ok;
    logic [1:0]             svc_code;
    logic                   svc_any;

    // ==========================================================
    // pin synchronisers and channels
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            fcct_sync u_sync (
                .clk_i   (clk_i),
                .rst_n_i (rst_n_i),
                .d_i     (count_trigger_in_i[g]),
                .q_o     (trig_s[g])
            );
            fcct_channel #(.DW(DW)) u_ch (
                .clk_i   (clk_i),
                .rst_n_i (rst_n_i),
                .wr_i    (wr_ch[g]),
                .wdata_i (data_i),
                .trig_i  (trig_s[g]),
                .count_o (cnt[g]),
                .ctrl_o  (ctrl[g]),
                .zero_o  (zero[g])
            );
        end
    endgenerate

    // ==========================================================
    // bus decode: one write per assertion of the access
    always_comb begin
        sel       = {channel_select_hi_i, channel_select_lo_i};
        io_acc    = ~chip_en_n_i & ~ioreq_n_i & m1_n_i;
        wr_stb    = io_acc & rd_n_i & ~st_q.acc_old;
        ack       = ~ioreq_n_i & ~m1_n_i;
        fetch     = ~m1_n_i & ~rd_n_i & ioreq_n_i;
        fetch_end = st_q.fetch_old & ~fetch;
        wr_ch     = '0;
        // vector words go to the shared base, not a channel
        if (wr_stb && data_i[fcct_pkg::CW_CTRL_BIT]) begin
            wr_ch[sel] = 1'b1;
        end
        // a channel expecting its constant takes any byte
        for (int i = 0; i < NCH; i++) begin
            if (wr_stb && sel == i[1:0] && ctrl[i][fcct_pkg::CW_TC_BIT] &&
                !data_i[fcct_pkg::CW_CTRL_BIT]) begin
                wr_ch[i] = 1'b1;
            end
        end
    end

    // ==========================================================
    // priority: lowest-numbered pending channel not blocked by service
    always_comb begin
        pend_next = st_q.pend;
        for (int i = 0; i < NCH; i++) begin
            if (zero[i] && ctrl[i][fcct_pkg::CW_IE_BIT]) begin
                pend_next[i] = 1'b1;
            end
            if (!ctrl[i][fcct_pkg::CW_IE_BIT]) begin
                pend_next[i] = 1'b0;
            end
        end
        svc_mask = '0;
        svc_any  = 1'b0;
        svc_code = 2'b00;
        // channels at or below the highest in service are blocked
        for (int i = NCH - 1; i >= 0; i--) begin
            if (st_q.insvc[i]) begin
                svc_any  = 1'b1;
                svc_code = i[1:0];
            end
        end
        for (int i = 0; i < NCH; i++) begin
            svc_mask[i] = svc_any && (i[1:0] >= svc_code);
        end
        win_ok   = 1'b0;
        win_code = 2'b00;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (st_q.pend[i] && !svc_mask[i]) begin
                win_ok   = 1'b1;
                win_code = i[1:0];
            end
        end
    end

    // ==========================================================
    // next state
    always_comb begin
        st_d           = st_q;
        st_d.acc_old   = io_acc;
        st_d.fetch_old = fetch;
        st_d.pend      = pend_next;
        st_d.drive     = 1'b0;
        st_d.rdata     = '0;
        if (io_acc && !rd_n_i) begin
            st_d.drive = 1'b1;
            st_d.rdata = cnt[sel];
        end
        if (wr_stb && !data_i[fcct_pkg::CW_CTRL_BIT] && wr_ch == '0) begin
            st_d.vec_base = data_i[DW-1:fcct_pkg::VEC_BASE_LSB];
        end
        // acknowledge: vector picked on the first cycle stands until release,
        // since acc_old is set after the first cycle and holds drive and rdata while ack stays asserted
        if (ack && st_q.acc_old) begin
            st_d.drive = st_q.drive;
            st_d.rdata = st_q.rdata;
        end else if (ack && priority_chain_in_i && win_ok) begin
            st_d.drive = 1'b1;
            st_d.rdata = {st_q.vec_base, win_code, 1'b0};
            // a zero in the same cycle is a new request: set wins
            st_d.pend[win_code]  = zero[win_code] &
                                   ctrl[win_code][fcct_pkg::CW_IE_BIT];
            st_d.insvc[win_code] = 1'b1;
        end
        st_d.acc_old = io_acc | ack;
        // return opcode pair on consecutive fetches; byte taken at fetch end
        if (fetch_end) begin
            st_d.saw_prefix = 1'b0;
            if (st_q.saw_prefix && data_i == fcct_pkg::RET_OP_SECOND &&
                priority_chain_in_i && svc_any) begin
                st_d.insvc[svc_code] = 1'b0;
            end else if (data_i == fcct_pkg::RET_OP_PREFIX) begin
                st_d.saw_prefix = 1'b1;
            end
        end
        for (int i = 0; i < 3; i++) begin
            st_d.zc[i] = zero[i];
        end
        st_d.irq       = |(st_d.pend & ~svc_mask);
        st_d.chain_out = priority_chain_in_i & ~(|st_d.insvc);
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // chain out lags chain in by one cycle; registered outputs except int_n_o, tied low
    assign data_o                 = st_q.rdata;
    assign data_oe_n_o            = ~st_q.drive;
    assign zero_count_pulse_out_o = st_q.zc;
    assign int_n_o                = 1'b0;
    assign int_oe_n_o             = ~st_q.irq;
    assign priority_chain_out_o   = st_q.chain_out;
endmodule : fcct_top
`default_nettype wire

/* File: fcct_props.sv */
// Purpose: port-level checks for the four-channel counter/timer
// Assumes: strobes and chain input are sampled on the rising clk_i edge
// Notes:   bound to every fcct_top instance, sees only its ports
`timescale 1ns/1ps
`default_nettype none
module fcct_props #(
    parameter int unsigned NCH = 4,
    parameter int unsigned DW  = 8
) (
    input wire logic           clk_i,
    input wire logic           rst_n_i,
    input wire logic           chip_en_n_i,
    input wire logic           ioreq_n_i,
    input wire logic           rd_n_i,
    input wire logic           m1_n_i,
    input wire logic           channel_select_lo_i,
    input wire logic           channel_select_hi_i,
    input wire logic [DW-1:0]  data_i,
    input wire logic [DW-1:0]  data_o,
    input wire logic           data_oe_n_o,
    input wire logic [NCH-1:0] count_trigger_in_i,
    input wire logic [2:0]     zero_count_pulse_out_o,
    input wire logic           int_n_o,
    input wire logic           int_oe_n_o,
    input wire logic           priority_chain_in_i,
    input wire logic           priority_chain_out_o
);
    // ==========================================================
    // bus, chain and pulse relations, one clock domain
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_reset_quiet: assert property ($rose(rst_n_i) |-> data_oe_n_o && int_oe_n_o
        && zero_count_pulse_out_o == 3'h0) else $error("outputs not idle after reset");
    a_chain_gate: assert property (priority_chain_out_o |-> $past(priority_chain_in_i))
        else $error("chain out high without chain in");
    a_read_answer: assert property ((!chip_en_n_i && !ioreq_n_i && !rd_n_i && m1_n_i)
        |=> !data_oe_n_o) else $error("read not answered");
    a_write_quiet: assert property ((!chip_en_n_i && !ioreq_n_i && rd_n_i && m1_n_i)
        |=> data_oe_n_o) else $error("bus driven during write");
    a_fetch_quiet: assert property (ioreq_n_i [*2] |-> data_oe_n_o)
        else $error("bus driven outside an i/o cycle");
    a_ack_refused: assert property ((!ioreq_n_i && !m1_n_i && !priority_chain_in_i) [*2]
        |-> data_oe_n_o) else $error("vector driven without chain in");
    a_vector_lsb: assert property ((!ioreq_n_i && !m1_n_i && !data_oe_n_o)
        |-> data_o[0] == 1'b0) else $error("vector low bit not zero");
    a_service_blocks: assert property ((!ioreq_n_i && !m1_n_i && !data_oe_n_o)
        |-> ##[1:2] !priority_chain_out_o) else $error("chain out high in service");
    a_zc_single: assert property ((zero_count_pulse_out_o & $past(zero_count_pulse_out_o))
        == 3'h0) else $error("zero-count pulse longer than one cycle");
    a_int_level: assert property (int_n_o == 1'b0) else $error("open-drain level not low");
endmodule : fcct_props
bind fcct_top fcct_props #(.NCH(NCH), .DW(DW)) u_fcct_props (.clk_i, .rst_n_i, .chip_en_n_i,
    .ioreq_n_i, .rd_n_i, .m1_n_i, .channel_select_lo_i, .channel_select_hi_i, .data_i, .data_o,
    .data_oe_n_o, .count_trigger_in_i, .zero_count_pulse_out_o, .int_n_o, .int_oe_n_o,
    .priority_chain_in_i, .priority_chain_out_o);
`default_nettype wire

/* File: fcct_host.sv */
// Purpose: host processor model on the parallel I/O bus
// Assumes: strobes change at the falling clock edge only
// Notes:   tasks are called from the bench top; one access per call
`timescale 1ns/1ps
`default_nettype none
module fcct_host (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rdata_oe_n_i,
    output logic            chip_en_n_o,
    output logic            ioreq_n_o,
    output logic            rd_n_o,
    output logic            m1_n_o,
    output logic            sel_lo_o,
    output logic            sel_hi_o,
    output logic [7:0]      wdata_o
);
    // ==========================================================
    // idle strobes; select and data stay unknown until the first access,
    // and a released data byte shows its inverse, not a stale copy
    initial begin
        {chip_en_n_o, ioreq_n_o, rd_n_o, m1_n_o} = 4'hf;
    end
    // write; control word and constant go as back-to-back calls
    task automatic bus_wr(input logic [1:0] ch, input logic [7:0] b);
        @(negedge clk_i);
        {sel_hi_o, sel_lo_o} = ch;
        wdata_o = b;
        {chip_en_n_o, ioreq_n_o} = 2'h0;
        @(negedge clk_i);
        {chip_en_n_o, ioreq_n_o} = 2'h3;
        wdata_o = ~b;
        @(negedge clk_i);
    endtask : bus_wr
    // read (ack low) or vectored acknowledge (ack high), held two edges
    task automatic bus_rd(input logic [1:0] ch, input logic ack, output logic [7:0] v,
                          output logic oe_n);
        @(negedge clk_i);
        {sel_hi_o, sel_lo_o} = ch;
        {chip_en_n_o, ioreq_n_o, rd_n_o, m1_n_o} = {ack, 1'b0, ack, !ack};
        repeat (2) @(negedge clk_i);
        v = rdata_i;
        oe_n = rdata_oe_n_i;
        {chip_en_n_o, ioreq_n_o, rd_n_o, m1_n_o} = 4'hf;
        @(negedge clk_i);
    endtask : bus_rd
    // opcode fetch; byte stays one cycle past the strobes
    task automatic fetch(input logic [7:0] b);
        @(negedge clk_i);
        wdata_o = b;
        {rd_n_o, m1_n_o} = 2'h0;
        @(negedge clk_i);
        {rd_n_o, m1_n_o} = 2'h3;
        @(negedge clk_i);
        wdata_o = ~b;
    endtask : fetch
endmodule : fcct_host
`default_nettype wire

/* File: four_channel_counter_timer_tb_top.sv */
// Purpose: self-checking bench for the four-channel counter/timer
// Assumes: host model owns the bus; bench owns triggers, chain input, reset
// Notes:   integer model predicts counts, pulses and vectors
`timescale 1ns/1ps
`default_nettype none
module four_channel_counter_timer_tb_top;
    logic            clk_i = 1'b0;
    logic            rst_n_i = 1'b0;
    logic            chain_in = 1'b1;
    logic [3:0]      trig = 4'h0;
    wire logic       ce_n, ioreq_n, rd_n, m1_n, sel_lo, sel_hi, oe_n, int_n, int_oe_n, chain_out;
    wire logic [7:0] wdata, rdata;
    wire logic [2:0] zc;
    int              err_count = 0;
    int              compares = 0;
    int              tc[4], cnt[4], zce[3], zcs[3], last[3], prev[3], cyc;
    logic            cmode[4];
    logic [7:0]      v, vb;
    logic            o;
    always #12.5 clk_i = ~clk_i;
    // pulse monitor: sampled mid-cycle, away from the edge that launches zc
    always @(negedge clk_i) begin
        cyc++;
        for (int k = 0; k < 3; k++) begin
            if (zc[k] === 1'b1) begin
                zcs[k]++;
                prev[k] = last[k];
                last[k] = cyc;
            end
        end
    end
    fcct_host u_host (.clk_i(clk_i), .rdata_i(rdata), .rdata_oe_n_i(oe_n), .chip_en_n_o(ce_n),
        .ioreq_n_o(ioreq_n), .rd_n_o(rd_n), .m1_n_o(m1_n), .sel_lo_o(sel_lo), .sel_hi_o(sel_hi),
        .wdata_o(wdata));
    fcct_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .chip_en_n_i(ce_n), .ioreq_n_i(ioreq_n),
        .rd_n_i(rd_n), .m1_n_i(m1_n), .channel_select_lo_i(sel_lo), .channel_select_hi_i(sel_hi),
        .data_i(wdata), .data_o(rdata), .data_oe_n_o(oe_n), .count_trigger_in_i(trig),
        .zero_count_pulse_out_o(zc), .int_n_o(int_n), .int_oe_n_o(int_oe_n),
        .priority_chain_in_i(chain_in), .priority_chain_out_o(chain_out));
    // ==========================================================
    // checking and closing
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR at %0t ns: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    // ==========================================================
    // model-backed stimulus helpers
    task automatic prog(input int ch, input logic [7:0] cw, input logic [7:0] c);
        u_host.bus_wr(2'(ch), cw);
        u_host.bus_wr(2'(ch), c);
        tc[ch] = (c == 8'h00) ? 256 : int'(c);
        cnt[ch] = tc[ch];
        cmode[ch] = cw[6];
    endtask : prog
    task automatic pulse(input logic [3:0] m);
        @(negedge clk_i);
        trig = trig | m;
        repeat (4) @(negedge clk_i);
        trig = trig & ~m;
        repeat (6) @(negedge clk_i);
        for (int k = 0; k < 4; k++) begin
            if (m[k] && cmode[k]) begin
                cnt[k] = (cnt[k] == 1) ? tc[k] : cnt[k] - 1;
                if (cnt[k] == tc[k] && k < 3) begin
                    zce[k]++;
                end
            end
        end
    endtask : pulse
    task automatic rdchk(input int ch);
        u_host.bus_rd(2'(ch), 1'b0, v, o);
        chk({o, v}, 32'(cnt[ch] % 256));
    endtask : rdchk
    // watchdog: the whole sequence needs well under 5000 cycles
    initial begin
        #(25 * 20000);
        err_count++;
        final_report();
    end
    initial begin
        int n;
        void'($urandom(32'h776ab5d8));
        repeat (4) @(negedge clk_i);
        rst_n_i = 1'b1;
        @(negedge clk_i);
        chk({oe_n, int_oe_n, zc, chain_out}, 32'h31);
        $display("test reset done");
        // counter mode everywhere, random edge; channel 3 takes the 256 case
        for (int k = 0; k < 4; k++) begin
            prog(k, 8'h45 | 8'($urandom & 32'h10),
                 (k == 3) ? 8'h00 : (k == 0) ? 8'h02 : 8'($urandom_range(255, 3)));
        end
        for (int k = 0; k < 4; k++) rdchk(k);
        n = $urandom_range(6, 3);
        repeat (n) pulse(4'hf);
        for (int k = 0; k < 4; k++) rdchk(k);
        for (int k = 0; k < 3; k++) chk(zcs[k], zce[k]);
        $display("test counter done");
        // timer mode: pulse spacing is prescale times constant
        n = $urandom_range(3, 1);
        // soft reset first: a running channel would finish its old count
        prog(2, 8'h07, 8'(n));
        repeat (16 * n * 3 + 40) @(negedge clk_i);
        chk(last[2] - prev[2], 16 * n);
        prog(2, 8'h27, 8'h01);
        repeat (552) @(negedge clk_i);
        chk(last[2] - prev[2], 256);
        u_host.bus_wr(2'h2, 8'h03);
        prog(2, 8'h0d, 8'h01);
        n = zcs[2];
        repeat (100) @(negedge clk_i);
        chk(zcs[2], n);
        pulse(4'h4);
        repeat (40) @(negedge clk_i);
        chk(32'(zcs[2] > n), 1);
        $display("test timer done");
        // two requests at once, chain blocking and return decoding
        vb = 8'($urandom) & 8'hf8;
        prog(1, 8'hc7, 8'h01);
        prog(3, 8'hc7, 8'h01);
        u_host.bus_wr(2'h0, vb);
        pulse(4'ha);
        chk(int_oe_n, 1'b0);
        chain_in = 1'b0;
        u_host.bus_rd(2'h0, 1'b1, v, o);
        chk(o, 1'b1);
        chain_in = 1'b1;
        u_host.bus_rd(2'h0, 1'b1, v, o);
        chk({o, v}, {1'b0, vb | 8'h02});
        chk({chain_out, int_oe_n}, 2'h1);
        u_host.bus_rd(2'h0, 1'b1, v, o);
        chk(o, 1'b1);
        u_host.fetch(8'hed);
        u_host.fetch(8'h00);
        u_host.fetch(8'h4d);
        chk(chain_out, 1'b0);
        u_host.fetch(8'hed);
        u_host.fetch(8'h4d);
        chk(chain_out, 1'b1);
        u_host.bus_rd(2'h0, 1'b1, v, o);
        chk({o, v}, {1'b0, vb | 8'h06});
        u_host.fetch(8'hed);
        u_host.fetch(8'h4d);
        chk({chain_out, int_oe_n}, 2'h3);
        $display("test interrupt done");
        // soft reset stops channel 0; hardware reset mid-run stops channel 1
        u_host.bus_wr(2'h0, 8'h43);
        n = zcs[0];
        repeat (3) pulse(4'h1);
        chk(zcs[0], n);
        prog(1, 8'hc5, 8'h01);
        pulse(4'h2);
        rst_n_i = 1'b0;
        repeat (4) @(negedge clk_i);
        rst_n_i = 1'b1;
        n = zcs[1];
        pulse(4'h2);
        chk({int_oe_n, zcs[1] == n}, 2'h3);
        $display("test reset stop done");
        final_report();
    end
endmodule : four_channel_counter_timer_tb_top
`default_nettype wire
